// File: design/aux_cmd_pkg.sv
// Purpose: shared constants and types of the auxiliary serial-flash command unit
// Assumes: system clock of 125 MHz, serial clock framed by an active-low select
// Notes: busy times below are plain defaults, scaled into cycles by cyc_of()
// ==========================================================================
// Summary of operation
// - Opcode 53h/55h plus three address bytes requests page copy into buffer one/two.
// - Page copy starts at select rise; ready flag low until copy time elapses.
// - Opcode 60h/61h plus address bytes selects page compare against buffer one/two.
// - At select rise compare runs busy for compare time, then result lands in bit 6.
// - Opcode 58h/59h without data copies page to buffer then rewrites it, busy throughout.
// - Data bytes after 58h/59h address turn the command into read-modify-write.
// - Two-byte status read D7h is accepted at any time, even while busy.
// - Configuration writes alter only the quad enable bit, nothing else.
// - Sequence 3Dh 2Ah 81h 66h programs quad enable to one.
// - Sequence 3Dh 2Ah 81h 67h programs quad enable to zero.
// - After opcode 25h the serial output line shows readiness directly.
// - Software reset only on F0h 00h 00h 00h received while select is low.
// - 264-byte pages: 24 address bits, page in bits 23:9, byte bits ignored.
// - 256-byte pages: 23 address bits, page in bits 22:8, low 8 ignored.
// - Status bit 6 is one when any compared bit differs, zero on match.
// - Bit 7 of both status bytes is zero while busy, one when ready.
// - While a buffer's program is suspended, commands modifying that buffer are ignored.
package aux_cmd_pkg;
   // ==========================================================================
   // Opcodes and multi-byte sequences
   localparam logic [7:0] OPC_XFER_B1 = 8'h53;
   localparam logic [7:0] OPC_XFER_B2 = 8'h55;
   localparam logic [7:0] OPC_CMP_B1 = 8'h60;
   localparam logic [7:0] OPC_CMP_B2 = 8'h61;
   localparam logic [7:0] OPC_REWR_B1 = 8'h58;
   localparam logic [7:0] OPC_REWR_B2 = 8'h59;
   localparam logic [7:0] OPC_STATUS_RD = 8'hd7;
   localparam logic [7:0] OPC_CONFIG_RD = 8'h3f;
   localparam logic [7:0] OPC_CONFIG_WR = 8'h3d;
   localparam logic [7:0] OPC_ACT_INT = 8'h25;
   localparam logic [7:0] OPC_SW_RESET = 8'hf0;
   localparam logic [23:0] SEQ_QUAD_ON = 24'h2a8166;
   localparam logic [23:0] SEQ_QUAD_OFF = 24'h2a8167;
   localparam logic [23:0] SEQ_SW_RESET = 24'h000000;
   // ==========================================================================
   // Frame sizes and register layouts
   localparam logic [2:0] BYTES_CMD = 3'h4;
   localparam logic [2:0] BYTES_MAX = 3'h5;
   localparam logic [3:0] DENSITY_CODE = 4'hd;
   localparam logic [6:0] CFG_FIXED_BITS = 7'h08;
   localparam logic QE_RESET = 1'b0;
   // ==========================================================================
   // Busy times in ns and cycle conversion
   localparam longint SYS_CLK_MHZ = 125;
   localparam longint PAGE_COPY_TIME_NS = 200000;
   localparam longint PAGE_COMPARE_TIME_NS = 200000;
   localparam longint PAGE_REWRITE_TIME_NS = 20000000;
   localparam longint CONFIG_PROG_TIME_NS = 15000000;
   function automatic int unsigned cyc_of(input longint ns);
      longint c;
      c = (ns * SYS_CLK_MHZ + 999) / 1000;
      if (c < 1) begin
         c = 1;
      end
      return int'(c);
   endfunction
   typedef enum logic [2:0] {OP_NONE, OP_XFER, OP_CMP, OP_REWRITE, OP_RMW, OP_CFG_PROG} op_e;
   typedef enum logic {ST_IDLE, ST_BUSY} state_e;
endpackage

// File: design/link_if.sv
// Purpose: carrier between the serial-clock front end and the command core
// Assumes: frame fields are held steady while select is high
// Notes: status and config levels are synchronised inside the front end
`timescale 1ns/1ps
`default_nettype none
interface link_if;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [2:0] byte_cnt;
   logic frame_tgl;
   logic opc_valid;
   logic so_bit;
   logic [15:0] status_word;
   logic [7:0] config_byte;
   modport link (output opcode, addr, byte_cnt, frame_tgl, opc_valid, so_bit,
                 input status_word, config_byte);
   modport core (input opcode, addr, byte_cnt, frame_tgl, opc_valid, so_bit,
                 output status_word, config_byte);
endinterface
`default_nettype wire

// File: design/spi_link.sv
// Purpose: serial-clock front end: shifts in opcode and address, shifts out status
// Assumes: SPI mode 0, data sampled and launched on the rising serial clock
// Notes: per-frame flags clear asynchronously while select is high
`timescale 1ns/1ps
`default_nettype none
module spi_link import aux_cmd_pkg::*; (
   input wire logic srst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   link_if.link lk
);
   logic [7:0] sh_r, sh_nxt, opc_r, opc_nxt, byte_in, cur_opc;
   logic [2:0] bit_r, bit_nxt, bcnt_r, bcnt_nxt, base;
   logic [23:0] adr_r, adr_nxt, st_s1_r, st_s2_r;
   logic tg_r, tg_nxt, fresh_r, ov_r, ov_nxt, so_r, so_nxt, done;
   logic [3:0] tx_r, tx_nxt;

   // ==========================================================================
   // Byte assembly; a fresh frame restarts the counts without clearing fields
   always_comb begin
      byte_in = {sh_r[6:0], spi_si};
      sh_nxt = byte_in;
      base = fresh_r ? 3'h0 : bcnt_r;
      done = !fresh_r && (bit_r == 3'h7);
      bit_nxt = fresh_r ? 3'h1 : bit_r + 3'h1;
      bcnt_nxt = (done && base != BYTES_MAX) ? base + 3'h1 : base;
      tg_nxt = fresh_r ? ~tg_r : tg_r;
      opc_nxt = (done && base == 3'h0) ? byte_in : opc_r;
      adr_nxt = (done && base != 3'h0 && base < BYTES_CMD) ? {adr_r[15:0], byte_in} : adr_r;
      ov_nxt = ov_r | (done && base == 3'h0);
      cur_opc = ov_r ? opc_r : byte_in;
      // Status repeats every 16 bits, config byte every 8
      tx_nxt = ov_r ? tx_r + 4'h1 : 4'h0;
      // Concatenation keeps the inversion at three bits; config byte sits in bits 23:16
      so_nxt = (cur_opc == OPC_CONFIG_RD) ? st_s2_r[{2'b10, ~tx_nxt[2:0]}] : st_s2_r[~tx_nxt];
   end

   // Frame fields survive select rise so the core can read them afterwards
   always_ff @(posedge spi_sclk or posedge srst) begin
      if (srst) begin
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         bcnt_r <= 3'h0;
         opc_r <= 8'h00;
         adr_r <= 24'h000000;
         tg_r <= 1'b0;
         st_s1_r <= 24'h000000;
         st_s2_r <= 24'h000000;
      end else begin
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         bcnt_r <= bcnt_nxt;
         opc_r <= opc_nxt;
         adr_r <= adr_nxt;
         tg_r <= tg_nxt;
         st_s1_r <= {lk.config_byte, lk.status_word};
         st_s2_r <= st_s1_r;
      end
   end

   // Per-frame state, ended by the frame's own select
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         fresh_r <= 1'b1;
         ov_r <= 1'b0;
         tx_r <= 4'h0;
         so_r <= 1'b0;
      end else begin
         fresh_r <= 1'b0;
         ov_r <= ov_nxt;
         tx_r <= tx_nxt;
         so_r <= so_nxt;
      end
   end

   assign lk.opcode = opc_r;
   assign lk.addr = adr_r;
   assign lk.byte_cnt = bcnt_r;
   assign lk.frame_tgl = tg_r;
   assign lk.opc_valid = ov_r;
   assign lk.so_bit = so_r;
endmodule // spi_link
`default_nettype wire

// File: design/aux_cmd_unit.sv
// Purpose: decodes and times the auxiliary page and configuration commands
// Assumes: status inputs come from logic on sys_clk; SPI pins are asynchronous
// Notes: array work is signalled by a start pulse; only its busy time is modelled
`timescale 1ns/1ps
`default_nettype none
module aux_cmd_unit import aux_cmd_pkg::*; #(
   parameter int unsigned COPY_CYC = cyc_of(PAGE_COPY_TIME_NS),
   parameter int unsigned CMP_CYC = cyc_of(PAGE_COMPARE_TIME_NS),
   parameter int unsigned REWRITE_CYC = cyc_of(PAGE_REWRITE_TIME_NS),
   parameter int unsigned CFG_CYC = cyc_of(CONFIG_PROG_TIME_NS)
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe_n,
   input wire logic page_size_256,
   input wire logic sector_protect,
   input wire logic program_error,
   input wire logic lockdown_enabled,
   input wire logic erase_suspended,
   input wire logic buffer_one_program_suspended,
   input wire logic buffer_two_program_suspended,
   input wire logic array_mismatch,
   output logic ready,
   output logic compare_mismatch,
   output logic quad_io_enable,
   output logic array_start,
   output op_e array_op,
   output logic [14:0] array_page,
   output logic array_buffer,
   output logic array_abort
);
   link_if lk ();

   spi_link u_link (
      .srst(srst),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .lk(lk)
   );

   // ==========================================================================
   // Address decode
   function automatic logic [14:0] page_of(input logic [23:0] a, input logic binary);
      return binary ? a[22:8] : a[23:9];
   endfunction

   function automatic logic is_buf_two(input logic [7:0] opc);
      return (opc == OPC_XFER_B2) || (opc == OPC_CMP_B2) || (opc == OPC_REWR_B2);
   endfunction

   // ==========================================================================
   // Crossings from the serial-clock side
   logic cs_s1_r, cs_s2_r, cs_s3_r, ov_s1_r, ov_s2_r, tg_s1_r, tg_s2_r, so_s1_r, so_s2_r;

   // Two stages each; select has a third, compared with the second to find its rise
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         ov_s1_r <= 1'b0;
         ov_s2_r <= 1'b0;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         so_s1_r <= 1'b0;
         so_s2_r <= 1'b0;
      end else begin
         cs_s1_r <= spi_cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         ov_s1_r <= lk.opc_valid;
         ov_s2_r <= ov_s1_r;
         tg_s1_r <= lk.frame_tgl;
         tg_s2_r <= tg_s1_r;
         so_s1_r <= lk.so_bit;
         so_s2_r <= so_s1_r;
      end
   end

   // ==========================================================================
   // Frame decode at select rise
   logic cs_rise, new_frame, full, exact, buf_two, susp_buf, susp_any, go, sw_reset, cfg_val;
   logic seen_tg_r;
   op_e dec_op;
   int unsigned dur;

   // Frame fields are steady here: the serial clock stops while select is high
   always_comb begin
      cs_rise = cs_s2_r && !cs_s3_r;
      new_frame = cs_rise && (tg_s2_r != seen_tg_r);
      full = lk.byte_cnt >= BYTES_CMD;
      exact = lk.byte_cnt == BYTES_CMD;
      buf_two = is_buf_two(lk.opcode);
      susp_buf = buf_two ? buffer_two_program_suspended : buffer_one_program_suspended;
      susp_any = buffer_one_program_suspended || buffer_two_program_suspended;
      cfg_val = lk.addr == SEQ_QUAD_ON;
      dec_op = OP_NONE;
      dur = 1;
      unique case (lk.opcode)
         OPC_XFER_B1, OPC_XFER_B2: begin
            if (full && !susp_buf) begin
               dec_op = OP_XFER;
               dur = COPY_CYC;
            end
         end
         OPC_CMP_B1, OPC_CMP_B2: begin
            if (full && !susp_buf) begin
               dec_op = OP_CMP;
               dur = CMP_CYC;
            end
         end
         OPC_REWR_B1, OPC_REWR_B2: begin
            // Rewrite and modify both overwrite a buffer, so any suspension blocks them
            if (full && !susp_any) begin
               dec_op = exact ? OP_REWRITE : OP_RMW;
               dur = REWRITE_CYC;
            end
         end
         OPC_CONFIG_WR: begin
            if (exact && (lk.addr == SEQ_QUAD_ON || lk.addr == SEQ_QUAD_OFF)) begin
               dec_op = OP_CFG_PROG;
               dur = CFG_CYC;
            end
         end
         default: begin
            dec_op = OP_NONE;
         end
      endcase
      go = new_frame && (dec_op != OP_NONE);
      sw_reset = new_frame && exact && lk.opcode == OPC_SW_RESET && lk.addr == SEQ_SW_RESET;
   end

   // ==========================================================================
   // Operation sequencer
   state_e st_r, st_nxt;
   op_e op_r, op_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [14:0] page_nxt;
   logic seen_tg_nxt, buf_nxt, rdy_nxt, comp_nxt, qe_nxt, cfg_r, cfg_nxt;
   logic start_nxt, abort_nxt, finish;

   // New work is taken only when idle; a busy device ignores it
   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      cnt_nxt = cnt_r;
      page_nxt = array_page;
      buf_nxt = array_buffer;
      rdy_nxt = ready;
      comp_nxt = compare_mismatch;
      qe_nxt = quad_io_enable;
      cfg_nxt = cfg_r;
      start_nxt = 1'b0;
      abort_nxt = 1'b0;
      finish = 1'b0;
      seen_tg_nxt = cs_rise ? tg_s2_r : seen_tg_r;
      unique case (st_r)
         ST_IDLE: begin
            if (go) begin
               st_nxt = ST_BUSY;
               op_nxt = dec_op;
               cnt_nxt = dur;
               page_nxt = page_of(lk.addr, page_size_256);
               buf_nxt = buf_two;
               cfg_nxt = cfg_val;
               start_nxt = 1'b1;
               rdy_nxt = 1'b0;
            end
         end
         ST_BUSY: begin
            if (sw_reset) begin
               st_nxt = ST_IDLE;
               abort_nxt = 1'b1;
               rdy_nxt = 1'b1;
            end else if (cnt_r == 32'h1) begin
               finish = 1'b1;
               st_nxt = ST_IDLE;
               rdy_nxt = 1'b1;
               if (op_r == OP_CMP) begin
                  comp_nxt = array_mismatch;
               end
               if (op_r == OP_CFG_PROG) begin
                  qe_nxt = cfg_r;
               end
            end else begin
               cnt_nxt = cnt_r - 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r <= ST_IDLE;
         op_r <= OP_NONE;
         cnt_r <= 32'h0;
         seen_tg_r <= 1'b0;
         cfg_r <= 1'b0;
         ready <= 1'b1;
         compare_mismatch <= 1'b0;
         quad_io_enable <= QE_RESET;
         array_start <= 1'b0;
         array_op <= OP_NONE;
         array_page <= 15'h0000;
         array_buffer <= 1'b0;
         array_abort <= 1'b0;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         cnt_r <= cnt_nxt;
         seen_tg_r <= seen_tg_nxt;
         cfg_r <= cfg_nxt;
         ready <= rdy_nxt;
         compare_mismatch <= comp_nxt;
         quad_io_enable <= qe_nxt;
         array_start <= start_nxt;
         array_op <= op_nxt;
         array_page <= page_nxt;
         array_buffer <= buf_nxt;
         array_abort <= abort_nxt;
      end
   end

   // ==========================================================================
   // Serial output and status words
   logic int_r, int_nxt, so_nxt, oe_n_nxt, drive;
   logic [15:0] stat_r, stat_nxt;

   // Status is registered here so the far side sees only flop outputs
   always_comb begin
      stat_nxt = {rdy_nxt, comp_nxt, DENSITY_CODE, sector_protect, page_size_256,
                  rdy_nxt, 1'b0, program_error, 1'b0, lockdown_enabled,
                  buffer_two_program_suspended, buffer_one_program_suspended, erase_suspended};
      drive = !cs_s2_r && ov_s2_r && (lk.opcode == OPC_STATUS_RD || lk.opcode == OPC_CONFIG_RD
                                      || lk.opcode == OPC_ACT_INT);
      int_nxt = drive && lk.opcode == OPC_ACT_INT;
      // Ready shown as a level; no serial clock is needed to watch it
      so_nxt = int_nxt ? ready : so_s2_r;
      oe_n_nxt = !drive;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         int_r <= 1'b0;
         stat_r <= 16'h0000;
         spi_so <= 1'b0;
         spi_so_oe_n <= 1'b1;
      end else begin
         int_r <= int_nxt;
         stat_r <= stat_nxt;
         spi_so <= so_nxt;
         spi_so_oe_n <= oe_n_nxt;
      end
   end

   assign lk.status_word = stat_r;
   assign lk.config_byte = {quad_io_enable, CFG_FIXED_BITS};

   // ==========================================================================
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   sequence s_took;
      array_start ##1 !ready;
   endsequence

   a_start_on_rise: assert property (array_start |-> $past(cs_rise) && !ready)
      else $error("array start without select rise or while ready");
   a_rewrite_busy: assert property (array_start && array_op == OP_REWRITE |-> s_took ##0 !ready [*4])
      else $error("rewrite released busy too soon");
   a_cmp_result: assert property (finish && op_r == OP_CMP |=> ready && compare_mismatch == $past(array_mismatch))
      else $error("compare result not stored at end of compare");
   a_rmw_select: assert property (go && st_r == ST_IDLE && lk.byte_cnt > BYTES_CMD
                                  && (lk.opcode == OPC_REWR_B1 || lk.opcode == OPC_REWR_B2)
                                  |=> array_op == OP_RMW)
      else $error("data bytes did not select read-modify-write");
   a_qe_only_cfg: assert property ($changed(quad_io_enable) |-> $past(finish && op_r == OP_CFG_PROG))
      else $error("quad enable changed outside configuration program");
   a_qe_value: assert property (finish && op_r == OP_CFG_PROG |=> quad_io_enable == $past(cfg_r))
      else $error("quad enable not programmed to requested value");
   a_short_drop: assert property (cs_rise && lk.byte_cnt < BYTES_CMD |=> !array_start)
      else $error("short frame started an operation");
   a_susp_block: assert property (new_frame && lk.opcode == OPC_XFER_B1 && buffer_one_program_suspended
                                  |=> !array_start)
      else $error("suspended buffer was modified");
   a_int_level: assert property (int_r |-> spi_so == $past(ready) && !spi_so_oe_n)
      else $error("ready not shown on serial output");
   a_reset_abort: assert property (sw_reset && st_r == ST_BUSY |=> ready && array_abort)
      else $error("software reset did not end busy operation");
endmodule // aux_cmd_unit
`default_nettype wire

// File: test/spi_host_model.sv
// Purpose: host-side serial master that frames commands for the command unit
// Assumes: mode 0, serial clock period 80 ns, clock parked low between frames
// Notes: data line shows the inverse of its last bit once a frame ends
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so
);
   // ==========================================================================
   // Idle levels
   // Deferred so the link's select-driven clear sees a rising edge at time zero
   initial begin
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_si <= 1'b1;
   end

   // Select rises off the serial clock; data inverted so no stale bit lingers
   task automatic end_frame();
      #20 spi_cs_n <= 1'b1;
      spi_si <= ~spi_si;
   endtask

   // ==========================================================================
   // One frame, MSB first from tx[63]; serial out sampled before each fall
   task automatic xfer(input logic [63:0] tx, input int nbits, input bit hold, output logic [31:0] rx);
      rx = '0;
      #100 spi_cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         #20 spi_si <= tx[63 - i];
         #20 spi_sclk <= 1'b1;
         #40 rx = {rx[30:0], spi_so};
         spi_sclk <= 1'b0;
      end
      if (!hold) begin
         end_frame();
      end
   endtask
endmodule // spi_host_model
`default_nettype wire

// File: test/serial_flash_aux_command_unit_tb_top.sv
// Purpose: self-checking bench of the auxiliary command unit
// Assumes: busy counts shortened by parameters; host model drives the link
// Notes: expectations come from opcodes, page fields and status layouts
`timescale 1ns/1ps
`default_nettype none
module serial_flash_aux_command_unit_tb_top import aux_cmd_pkg::*;;
   localparam int CP = 30;
   localparam int CM = 20;
   localparam int RW = 500;
   localparam int CF = 25;
   localparam logic [23:0] ADDR = 24'hb3c1ff;
   logic sys_clk = 1'b0;
   logic srst = 1'b0;
   wire spi_sclk, spi_cs_n, spi_si;
   logic spi_so, spi_so_oe_n, ready, compare_mismatch, quad_io_enable, array_start, array_buffer, array_abort;
   logic page_size_256 = 1'b0, sector_protect = 1'b0, program_error = 1'b0, lockdown_enabled = 1'b0;
   logic erase_suspended = 1'b0, bs1 = 1'b0, bs2 = 1'b0, array_mismatch = 1'b0;
   op_e array_op;
   logic [14:0] array_page;
   logic [31:0] rx;
   int error_cnt = 0, n_checks = 0, cyc = 0, t0 = 0;

   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;

   spi_host_model u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
   aux_cmd_unit #(.COPY_CYC(CP), .CMP_CYC(CM), .REWRITE_CYC(RW), .CFG_CYC(CF)) u_dut (
      .sys_clk(sys_clk), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .page_size_256(page_size_256),
      .sector_protect(sector_protect), .program_error(program_error), .lockdown_enabled(lockdown_enabled),
      .erase_suspended(erase_suspended), .buffer_one_program_suspended(bs1),
      .buffer_two_program_suspended(bs2), .array_mismatch(array_mismatch), .ready(ready),
      .compare_mismatch(compare_mismatch), .quad_io_enable(quad_io_enable), .array_start(array_start),
      .array_op(array_op), .array_page(array_page), .array_buffer(array_buffer), .array_abort(array_abort));

   // ==========================================================================
   // Shared compare, start watch and busy timing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask

   task automatic run_op(input logic [63:0] tx, input int nbits, input op_e op);
      bit got;
      got = 0;
      u_host.xfer(tx, nbits, 0, rx);
      for (int i = 0; i < 12 && !got; i++) begin
         @(posedge sys_clk);
         #1 got = (array_start === 1'b1);
      end
      t0 = cyc;
      chk(got, 1, "no start pulse");
      chk({ready, array_op}, {1'b0, op}, "operation code");
   endtask

   // Refused frames must leave the array untouched
   task automatic no_start(input logic [63:0] tx, input int nbits);
      bit got;
      got = 0;
      u_host.xfer(tx, nbits, 0, rx);
      repeat (12) begin
         @(posedge sys_clk);
         #1 got |= (array_start === 1'b1);
      end
      chk(got, 0, "refused frame started");
   endtask

   // Tolerance of one cycle covers the start-pulse sampling offset
   task automatic finish_busy(input int n);
      for (int w = 0; w < 1000 && ready !== 1'b1; w++) begin
         @(posedge sys_clk);
         #1;
      end
      chk((cyc - t0 >= n - 1) && (cyc - t0 <= n + 1), 1, "busy length");
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_xfer();
      run_op({8'h53, ADDR, 32'h0}, 32, OP_XFER);
      chk({array_page, array_buffer}, {ADDR[23:9], 1'b0}, "page 264");
      finish_busy(CP);
      @(posedge sys_clk);
      page_size_256 <= 1'b1;
      run_op({8'h55, ADDR, 32'h0}, 32, OP_XFER);
      chk({array_page, array_buffer}, {ADDR[22:8], 1'b1}, "page 256");
      finish_busy(CP);
      no_start({8'h53, ADDR[23:8], 40'h0}, 24);
   endtask

   task automatic t_compare();
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         array_mismatch <= ~i[0];
         run_op({i[0] ? 8'h61 : 8'h60, ADDR, 32'h0}, 32, OP_CMP);
         finish_busy(CM);
         chk(compare_mismatch, {~i[0]}, "compare result");
      end
   endtask

   task automatic t_suspend();
      @(posedge sys_clk);
      bs1 <= 1'b1;
      no_start({8'h53, ADDR, 32'h0}, 32);
      no_start({8'h60, ADDR, 32'h0}, 32);
      no_start({8'h58, ADDR, 32'h0}, 32);
      run_op({8'h55, ADDR, 32'h0}, 32, OP_XFER);
      finish_busy(CP);
      @(posedge sys_clk);
      bs1 <= 1'b0;
   endtask

   task automatic t_quad();
      for (int i = 0; i < 2; i++) begin
         run_op({8'h3d, i[0] ? SEQ_QUAD_OFF : SEQ_QUAD_ON, 32'h0}, 32, OP_CFG_PROG);
         finish_busy(CF);
         chk(quad_io_enable, {~i[0]}, "quad enable");
         u_host.xfer({8'h3f, 56'h0}, 15, 0, rx);
         chk(rx[7:0], {~i[0], 7'h08}, "config byte");
      end
   endtask

   task automatic t_rewrite();
      run_op({8'h58, ADDR, 32'h0}, 32, OP_REWRITE);
      finish_busy(RW);
      run_op({8'h59, ADDR, 8'h77, 24'h0}, 40, OP_RMW);
      @(posedge sys_clk);
      sector_protect <= 1'b1;
      program_error <= 1'b1;
      erase_suspended <= 1'b1;
      lockdown_enabled <= 1'b1;
      bs1 <= 1'b1;
      bs2 <= 1'b1;
      u_host.xfer({8'hd7, 56'h0}, 23, 0, rx);
      chk(rx[15:0], {1'b0, 1'b0, 4'hd, 1'b1, 1'b1, 8'h2f}, "status while busy");
      u_host.xfer({8'h25, 56'h0}, 8, 1, rx);
      repeat (6) @(posedge sys_clk);
      #1 chk({spi_so_oe_n, spi_so}, 2'b00, "busy on serial out");
      finish_busy(RW);
      repeat (2) @(posedge sys_clk);
      #1 chk({spi_so_oe_n, spi_so}, 2'b01, "ready on serial out");
      u_host.end_frame();
      @(posedge sys_clk);
      bs1 <= 1'b0;
      bs2 <= 1'b0;
   endtask

   task automatic t_swreset();
      bit got;
      got = 0;
      run_op({8'h58, ADDR, 32'h0}, 32, OP_REWRITE);
      u_host.xfer({8'hf0, SEQ_SW_RESET, 32'h0}, 32, 0, rx);
      for (int i = 0; i < 12 && !got; i++) begin
         @(posedge sys_clk);
         #1 got = (array_abort === 1'b1);
      end
      chk({got, ready}, 2'b11, "software reset");
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      // Deferred rise gives the link-side flops an edge to clear on
      srst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk({ready, spi_so_oe_n, quad_io_enable, array_start}, 4'hc, "reset levels");
      t_xfer();
      t_compare();
      t_suspend();
      t_quad();
      t_rewrite();
      t_swreset();
      wrap_up();
   end

   initial begin
      #400000;
      error_cnt++;
      $display("mismatch %0t watchdog expired", $time);
      wrap_up();
   end
endmodule // serial_flash_aux_command_unit_tb_top
`default_nettype wire
